// ===== zero_servo_torque_select.sv
// Position-hold and torque-reference selection for a motor drive.
// Assumes synchronous inputs on clk_sys, settings presented on
// cfg_in with a one-cycle cfg_write strobe, and analog samples
// already converted to signed words.
`timescale 1ns/1ps

// Contract
// - Hold enabled only by input coded hold
// - Hold command and slow reference lock position
// - Run must stay on; off stops output
// - Achieved output only where selector holds code
// - Achieved while position within start plus or minus window
// - Window range zero to max, default ten
// - Gain zero to hundred, default five
// - Count every edge of both phases
// - Achieved drops when hold command drops
// - Gain and window locked while running
// - Zero speed, one torque, locked running
// - Torque control only in flux vector
// - Torque reference from analog input coded
// - Selector defaults and accepted code ranges
// - Level codes; current level only current
// - Torque direction from reference sign only
// - Unipolar levels accept forward torque only
module zero_servo_torque_select
   import zst_pkg::*;
#(
   parameter int POS_W = 32
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rstn,
   // Terminal function selectors
   input wire logic [DI_COUNT-1:0][FSEL_W-1:0] digital_input_function_select,
   input wire logic [DO_COUNT-1:0][FSEL_W-1:0] digital_output_function_select,
   // Settings; cfg_in written while stopped, flux_vector_mode and zero_speed_level used live
   input wire cfg_t cfg_in,
   input wire logic cfg_write,
   input wire logic flux_vector_mode,
   input wire logic [AIN_W-1:0] zero_speed_level,
   // Drive commands and inputs
   input wire logic run_cmd,
   input wire logic [DI_COUNT-1:0] digital_in,
   input wire logic signed [AIN_W-1:0] speed_ref,
   input wire logic enc_a,
   input wire logic enc_b,
   input wire logic signed [AIN_W-1:0] multi_input,
   input wire logic signed [AIN_W-1:0] current_input,
   // Settings status
   output cfg_t cfg_active,
   output logic cfg_accepted,
   output logic cfg_refused,
   // Drive status
   output logic drive_enable,
   output logic hold_active,
   output logic [DO_COUNT-1:0] digital_out,
   output logic signed [POS_W-1:0] position_count,
   output logic signed [POS_W-1:0] position_error,
   output logic signed [POS_W+GAIN_W:0] hold_correction,
   // Torque reference
   output logic torque_mode,
   output logic torque_ref_valid,
   output logic signed [AIN_W-1:0] torque_ref
);

   generate
      if (POS_W < WIN_W + 2) begin : g_bad_pos
         $error("zero_servo_torque_select: POS_W too narrow");
      end
   endgenerate

   // ----------------------------------------
   // Declarations
   // ----------------------------------------
   cfg_t cfg_reg;
   hold_state_t state_reg;
   hold_state_t state_next;
   logic signed [POS_W-1:0] start_pos_reg;
   logic signed [POS_W-1:0] pos_err;
   logic hold_entry;
   logic signed [POS_W-1:0] win_ext;
   logic [DI_COUNT-1:0] di_is_hold;
   logic [DO_COUNT-1:0] do_is_held;
   logic hold_enabled;
   logic hold_cmd;
   logic window_enabled;
   logic speed_low;
   logic [AIN_W-1:0] speed_mag;
   logic in_window;
   logic cfg_ok;
   logic signed [AIN_W-1:0] src_val;
   logic [LVL_W-1:0] src_lvl;
   logic src_found;

   // ----------------------------------------
   // Position counter
   // ----------------------------------------
   quad_counter #(
      .CNT_W(POS_W)
   ) u_counter (
      .clk_sys(clk_sys),
      .rstn(rstn),
      .phase_a(enc_a),
      .phase_b(enc_b),
      .count(position_count)
   );

   // ----------------------------------------
   // Settings check and latch
   // ----------------------------------------
   // Range limits; out-of-range writes are refused whole
   always_comb begin
      cfg_ok = 1'b1;
      if (cfg_in.hold_gain > GAIN_MAX) begin
         cfg_ok = 1'b0;
      end
      if (cfg_in.hold_window_count > WIN_MAX) begin
         cfg_ok = 1'b0;
      end
      if (cfg_in.multi_input_function_select > AIN_FUNC_MAX) begin
         cfg_ok = 1'b0;
      end
      if (cfg_in.current_input_function_select < CUR_FUNC_MIN) begin
         cfg_ok = 1'b0;
      end
      if (cfg_in.multi_input_level_select > LVL_BIPOLAR) begin
         cfg_ok = 1'b0;
      end
      if (cfg_in.current_input_level_select > LVL_CURRENT) begin
         cfg_ok = 1'b0;
      end
      if (cfg_in.control_type_select == CTRL_TORQUE &&
          !flux_vector_mode) begin
         cfg_ok = 1'b0;
      end
   end

   // Settings only move while the drive is stopped
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         cfg_reg <= CFG_RST;
         cfg_accepted <= 1'b0;
         cfg_refused <= 1'b0;
      end else begin
         cfg_accepted <= 1'b0;
         cfg_refused <= 1'b0;
         if (cfg_write) begin
            if (run_cmd || !cfg_ok) begin
               cfg_refused <= 1'b1;
            end else begin
               cfg_reg <= cfg_in;
               cfg_accepted <= 1'b1;
            end
         end
      end
   end

   assign cfg_active = cfg_reg;

   // ----------------------------------------
   // Terminal decode
   // ----------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < DI_COUNT; gi++) begin : g_di
         assign di_is_hold[gi] =
            digital_input_function_select[gi] == DI_FUNC_HOLD;
      end
      for (gi = 0; gi < DO_COUNT; gi++) begin : g_do
         assign do_is_held[gi] =
            digital_output_function_select[gi] == DO_FUNC_HELD;
      end
   endgenerate

   assign hold_enabled = |di_is_hold;
   assign hold_cmd = |(di_is_hold & digital_in);
   assign window_enabled = |do_is_held;

   // ----------------------------------------
   // Zero-speed compare
   // ----------------------------------------
   // Magnitude of the negative extreme saturates at the top
   always_comb begin
      if (speed_ref[AIN_W-1]) begin
         speed_mag = AIN_W'(-speed_ref);
         if (speed_mag[AIN_W-1]) begin
            speed_mag = {1'b0, {(AIN_W-1){1'b1}}};
         end
      end else begin
         speed_mag = speed_ref;
      end
   end

   assign speed_low = speed_mag < zero_speed_level;

   // ----------------------------------------
   // Hold state machine
   // ----------------------------------------
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         ST_STOP: begin
            // Hold may be asked for from the first running cycle
            if (run_cmd && hold_cmd && speed_low) begin
               state_next = ST_HOLD;
            end else if (run_cmd) begin
               state_next = ST_RUN;
            end
         end
         ST_RUN: begin
            if (!run_cmd) begin
               state_next = ST_STOP;
            end else if (hold_enabled && hold_cmd && speed_low) begin
               state_next = ST_HOLD;
            end
         end
         ST_HOLD: begin
            if (!run_cmd) begin
               state_next = ST_STOP;
            end else if (!hold_cmd || !speed_low) begin
               state_next = ST_RUN;
            end
         end
         default: begin
            state_next = ST_STOP;
         end
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         state_reg <= ST_STOP;
      end else begin
         state_reg <= state_next;
      end
   end

   // Start position taken on entry to hold
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         start_pos_reg <= '0;
      end else if (state_reg != ST_HOLD && state_next == ST_HOLD) begin
         start_pos_reg <= position_count;
      end
   end

   // ----------------------------------------
   // Position window
   // ----------------------------------------
   assign hold_entry = state_reg != ST_HOLD && state_next == ST_HOLD;
   // Entry cycle: start is the count being captured, not the stale one
   assign pos_err = hold_entry ? '0 : position_count - start_pos_reg;
   assign win_ext = POS_W'(cfg_reg.hold_window_count);
   assign in_window = (pos_err <= win_ext) && (pos_err >= -win_ext);

   // Status drops the same edge the command does
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         digital_out <= '0;
      end else if (state_next == ST_HOLD && hold_cmd &&
                   window_enabled && in_window) begin
         digital_out <= do_is_held;
      end else begin
         digital_out <= '0;
      end
   end

   // ----------------------------------------
   // Hold outputs
   // ----------------------------------------
   // Gain scales the restoring push; zero gain leaves only status
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         hold_active <= 1'b0;
         position_error <= '0;
         hold_correction <= '0;
      end else if (state_next == ST_HOLD) begin
         hold_active <= 1'b1;
         position_error <= pos_err;
         hold_correction <= -(pos_err *
            $signed({1'b0, cfg_reg.hold_gain}));
      end else begin
         hold_active <= 1'b0;
         position_error <= '0;
         hold_correction <= '0;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         drive_enable <= 1'b0;
      end else begin
         drive_enable <= run_cmd;
      end
   end

   // ----------------------------------------
   // Torque reference source
   // ----------------------------------------
   // No operator path exists: only the two analog inputs feed it
   always_comb begin
      src_found = 1'b0;
      src_val = '0;
      src_lvl = LVL_UNIPOLAR;
      if (cfg_reg.multi_input_function_select == AIN_FUNC_TORQUE) begin
         src_found = 1'b1;
         src_val = multi_input;
         src_lvl = cfg_reg.multi_input_level_select;
      end else if (cfg_reg.current_input_function_select ==
                   AIN_FUNC_TORQUE) begin
         src_found = 1'b1;
         src_val = current_input;
         src_lvl = cfg_reg.current_input_level_select;
      end
   end

   // Sign of the input alone sets direction; run direction unused
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         torque_mode <= 1'b0;
         torque_ref_valid <= 1'b0;
         torque_ref <= '0;
      end else begin
         torque_mode <= cfg_reg.control_type_select == CTRL_TORQUE &&
                        flux_vector_mode;
         torque_ref_valid <= src_found && run_cmd;
         if (!src_found || !run_cmd) begin
            torque_ref <= '0;
         end else if (src_lvl != LVL_BIPOLAR && src_val < 0) begin
            torque_ref <= '0;
         end else begin
            torque_ref <= src_val;
         end
      end
   end

endmodule

// ===== zst_pkg.sv
// Constants, field layouts and types for the position-hold and
// torque-reference selection block.
// Assumes a single 250 MHz system clock and synchronous inputs.
package zst_pkg;

   // ----------------------------------------
   // Counts of configurable terminals and of quadrature counts per line
   // ----------------------------------------
   localparam int DI_COUNT = 6;
   localparam int DO_COUNT = 3;
   localparam int QUAD_PER_LINE = 4;

   // ----------------------------------------
   // Field widths
   // ----------------------------------------
   localparam int FSEL_W = 8;
   localparam int ASEL_W = 5;
   localparam int LVL_W = 2;
   localparam int GAIN_W = 7;
   localparam int WIN_W = 14;
   localparam int AIN_W = 16;

   // ----------------------------------------
   // Function codes
   // ----------------------------------------
   localparam logic [FSEL_W-1:0] DI_FUNC_HOLD = 8'h72;
   localparam logic [FSEL_W-1:0] DO_FUNC_HELD = 8'h33;
   localparam logic [ASEL_W-1:0] AIN_FUNC_TORQUE = 5'h13;
   localparam logic [ASEL_W-1:0] AIN_FUNC_MAX = 5'h1f;
   localparam logic [ASEL_W-1:0] CUR_FUNC_MIN = 5'h01;

   // ----------------------------------------
   // Signal levels and control types
   // ----------------------------------------
   localparam logic [LVL_W-1:0] LVL_UNIPOLAR = 2'h0;
   localparam logic [LVL_W-1:0] LVL_BIPOLAR = 2'h1;
   localparam logic [LVL_W-1:0] LVL_CURRENT = 2'h2;
   localparam logic CTRL_SPEED = 1'b0;
   localparam logic CTRL_TORQUE = 1'b1;

   // ----------------------------------------
   // Limits and values after reset
   // ----------------------------------------
   localparam logic [GAIN_W-1:0] GAIN_MAX = 7'h64;
   localparam logic [GAIN_W-1:0] GAIN_RST = 7'h05;
   localparam logic [WIN_W-1:0] WIN_MAX = 14'h3fff;
   localparam logic [WIN_W-1:0] WIN_RST = 14'h000a;
   localparam logic [ASEL_W-1:0] ASEL_RST = 5'h1f;
   localparam logic [LVL_W-1:0] MULTI_LVL_RST = 2'h0;
   localparam logic [LVL_W-1:0] CUR_LVL_RST = 2'h2;

   // ----------------------------------------
   // Types
   // ----------------------------------------
   typedef struct packed {
      logic [GAIN_W-1:0] hold_gain;
      logic [WIN_W-1:0] hold_window_count;
      logic control_type_select;
      logic [ASEL_W-1:0] multi_input_function_select;
      logic [ASEL_W-1:0] current_input_function_select;
      logic [LVL_W-1:0] multi_input_level_select;
      logic [LVL_W-1:0] current_input_level_select;
   } cfg_t;

   localparam cfg_t CFG_RST = '{
      hold_gain: GAIN_RST,
      hold_window_count: WIN_RST,
      control_type_select: CTRL_SPEED,
      multi_input_function_select: ASEL_RST,
      current_input_function_select: ASEL_RST,
      multi_input_level_select: MULTI_LVL_RST,
      current_input_level_select: CUR_LVL_RST
   };

   typedef enum logic [2:0] {
      ST_STOP = 3'b001,
      ST_RUN = 3'b010,
      ST_HOLD = 3'b100
   } hold_state_t;

endpackage

// ===== quad_counter.sv
// Quadrature position counter for the shaft encoder phases.
// Assumes both phases are already synchronous to clk_sys.
`timescale 1ns/1ps
module quad_counter
   import zst_pkg::*;
#(
   parameter int CNT_W = 32
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rstn,
   // Encoder phases
   input wire logic phase_a,
   input wire logic phase_b,
   // Position
   output logic signed [CNT_W-1:0] count
);

   generate
      if (CNT_W < 16) begin : g_bad_width
         $error("quad_counter: CNT_W below 16");
      end
   endgenerate

   logic a_reg;
   logic b_reg;
   logic moved;
   logic fwd;

   // Any edge on either phase is one count
   assign moved = (phase_a ^ a_reg) | (phase_b ^ b_reg);
   // Direction from which phase leads
   assign fwd = phase_a ^ b_reg;

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         a_reg <= 1'b0;
         b_reg <= 1'b0;
      end else begin
         a_reg <= phase_a;
         b_reg <= phase_b;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         count <= '0;
      end else if (moved) begin
         if (fwd) begin
            count <= count + CNT_W'(1);
         end else begin
            count <= count - CNT_W'(1);
         end
      end
   end

endmodule

// ===== zst_monitor.sv
// Assertion checker for the position-hold and torque block.
// Bound into the top module; sees only its ports, one clock.
`timescale 1ns/1ps
module zst_monitor
   import zst_pkg::*;
#(
   parameter int POS_W = 32
) (
   // Clock, reset, settings
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic [DI_COUNT-1:0][FSEL_W-1:0] digital_input_function_select,
   input wire logic [DO_COUNT-1:0][FSEL_W-1:0] digital_output_function_select,
   input wire logic cfg_write,
   input wire logic flux_vector_mode,
   input wire logic [AIN_W-1:0] zero_speed_level,
   // Drive inputs
   input wire logic run_cmd,
   input wire logic [DI_COUNT-1:0] digital_in,
   input wire logic signed [AIN_W-1:0] speed_ref,
   input wire logic enc_a,
   input wire logic enc_b,
   input wire logic signed [AIN_W-1:0] multi_input,
   // Outputs
   input wire cfg_t cfg_active,
   input wire logic cfg_accepted,
   input wire logic cfg_refused,
   input wire logic drive_enable,
   input wire logic hold_active,
   input wire logic [DO_COUNT-1:0] digital_out,
   input wire logic signed [POS_W-1:0] position_count,
   input wire logic signed [POS_W-1:0] position_error,
   input wire logic torque_mode,
   input wire logic signed [AIN_W-1:0] torque_ref
);
   logic hold_cmd;
   logic slow;
   logic in_win;
   logic pa_q;
   logic pb_q;
   logic [DO_COUNT-1:0] held_sel;
   logic [AIN_W:0] spd_abs;
   logic [POS_W-1:0] err_abs;
   logic signed [POS_W-1:0] step;

   always_comb begin
      hold_cmd = 1'b0;
      for (int i = 0; i < DI_COUNT; i++) begin
         if (digital_input_function_select[i] == DI_FUNC_HOLD) begin
            hold_cmd = hold_cmd | digital_in[i];
         end
      end
      for (int i = 0; i < DO_COUNT; i++) begin
         held_sel[i] = digital_output_function_select[i] == DO_FUNC_HELD;
      end
      // Extra bit so the most negative reference has a magnitude
      spd_abs = {speed_ref[AIN_W-1], speed_ref};
      if (speed_ref < 0) begin
         spd_abs = -spd_abs;
      end
      slow = spd_abs < {1'b0, zero_speed_level};
      err_abs = position_error;
      if (position_error < 0) begin
         err_abs = -position_error;
      end
      in_win = err_abs <= POS_W'(cfg_active.hold_window_count);
   end

   // Phases seen at the previous edge give the expected count step
   always_ff @(posedge clk_sys) begin
      pa_q <= enc_a;
      pb_q <= enc_b;
   end

   always_comb begin
      step = '0;
      if (enc_a != pa_q && enc_b == pb_q) begin
         step = (enc_a != pb_q) ? 1 : -1;
      end else if (enc_b != pb_q && enc_a == pa_q) begin
         step = (enc_b == pa_q) ? 1 : -1;
      end
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rstn);

   chk_hold_code_only:
      assert property ($rose(hold_active) |->
         $past(hold_cmd) && $past(run_cmd))
      else $error("hold entered without coded command");
   chk_hold_entry:
      assert property (run_cmd && hold_cmd && slow |=> hold_active)
      else $error("hold not entered");
   chk_run_drop:
      assert property (!run_cmd |=> !hold_active && !drive_enable)
      else $error("run low but drive or hold on");
   chk_window_out:
      assert property (digital_out == ((hold_active && in_win) ? held_sel : '0))
      else $error("hold achieved output wrong");
   chk_cmd_drop:
      assert property (hold_active && !hold_cmd |=> digital_out == '0)
      else $error("achieved output kept after command drop");
   chk_cfg_locked:
      assert property (cfg_write && run_cmd |=>
         cfg_refused && !cfg_accepted && $stable(cfg_active))
      else $error("settings changed while running");
   chk_flux_only:
      assert property (!flux_vector_mode |=> !torque_mode)
      else $error("torque mode without flux vector");
   chk_torque_sign:
      assert property (run_cmd && !cfg_write &&
         cfg_active.multi_input_function_select == AIN_FUNC_TORQUE &&
         cfg_active.multi_input_level_select == LVL_BIPOLAR
         |=> torque_ref == $past(multi_input))
      else $error("torque reference not following input");
   chk_count_step:
      assert property (1'b1 |=>
         position_count == $past(position_count) + $past(step))
      else $error("position count step wrong");
endmodule

bind zero_servo_torque_select zst_monitor #(.POS_W(POS_W)) i_zst_monitor (
   .clk_sys, .rstn, .digital_input_function_select,
   .digital_output_function_select, .cfg_write, .flux_vector_mode,
   .zero_speed_level, .run_cmd, .digital_in, .speed_ref, .enc_a, .enc_b,
   .multi_input, .cfg_active, .cfg_accepted, .cfg_refused, .drive_enable,
   .hold_active, .digital_out, .position_count, .position_error,
   .torque_mode, .torque_ref
);

// ===== shaft_encoder_model.sv
// Behavioural shaft encoder giving two phases in quadrature.
// Assumes step requests change only between rising edges.
`timescale 1ns/1ps
module shaft_encoder_model (
   // Clock
   input wire logic clk_sys,
   // Motion requests
   input wire logic step_up,
   input wire logic step_dn,
   // Encoder phases
   output logic enc_a,
   output logic enc_b
);
   logic [1:0] pos_reg = 2'h0;

   always_ff @(posedge clk_sys) begin
      if (step_up) begin
         pos_reg <= pos_reg + 2'h1;
      end else if (step_dn) begin
         pos_reg <= pos_reg - 2'h1;
      end
   end

   // Forward motion: phase A leads, 00 10 11 01
   assign enc_a = pos_reg[1] ^ pos_reg[0];
   assign enc_b = pos_reg[1];
endmodule

// ===== testbench.sv
// Self-checking bench for the position-hold and torque block.
// Drives inputs on falling edges; encoder is a separate model.
`timescale 1ns/1ps
module testbench;
   import zst_pkg::*;

`define CHK(nm, exp, got) begin \
   cmp_count++; \
   if ((got) !== (exp)) begin \
      miscompares++; \
      $display("mismatch %s exp %0h got %0h", nm, exp, got); \
   end \
end

   logic clk_sys = 1'b0;
   logic rstn = 1'b0;
   logic [DI_COUNT-1:0][FSEL_W-1:0] di_sel = '0;
   logic [DO_COUNT-1:0][FSEL_W-1:0] do_sel = '0;
   cfg_t cfg_in = CFG_RST;
   cfg_t c;
   logic cfg_write = 1'b0;
   logic flux = 1'b0;
   logic [AIN_W-1:0] zsl = 16'h0100;
   logic run_cmd = 1'b0;
   logic [DI_COUNT-1:0] digital_in = '0;
   logic signed [AIN_W-1:0] speed_ref = '0;
   logic signed [AIN_W-1:0] multi_input = '0;
   logic signed [AIN_W-1:0] current_input = '0;
   logic step_up = 1'b0;
   logic step_dn = 1'b0;
   logic enc_a;
   logic enc_b;
   cfg_t cfg_active;
   logic cfg_accepted;
   logic cfg_refused;
   logic drive_enable;
   logic hold_active;
   logic [DO_COUNT-1:0] digital_out;
   logic signed [31:0] position_count;
   logic signed [31:0] position_error;
   logic signed [39:0] hold_corr;
   logic signed [31:0] exp_pos = '0;
   logic torque_mode;
   logic torque_ref_valid;
   logic signed [AIN_W-1:0] torque_ref;
   int miscompares = 0;
   int cmp_count = 0;

   always #2 clk_sys = ~clk_sys;

   zero_servo_torque_select #(.POS_W(32)) i_zero_servo_torque_select (
      .clk_sys(clk_sys), .rstn(rstn),
      .digital_input_function_select(di_sel),
      .digital_output_function_select(do_sel),
      .cfg_in(cfg_in), .cfg_write(cfg_write), .flux_vector_mode(flux),
      .zero_speed_level(zsl), .run_cmd(run_cmd),
      .digital_in(digital_in), .speed_ref(speed_ref), .enc_a(enc_a),
      .enc_b(enc_b), .multi_input(multi_input),
      .current_input(current_input), .cfg_active(cfg_active),
      .cfg_accepted(cfg_accepted), .cfg_refused(cfg_refused),
      .drive_enable(drive_enable), .hold_active(hold_active),
      .digital_out(digital_out), .position_count(position_count),
      .position_error(position_error), .hold_correction(hold_corr),
      .torque_mode(torque_mode), .torque_ref_valid(torque_ref_valid),
      .torque_ref(torque_ref)
   );

   shaft_encoder_model i_shaft_encoder_model (
      .clk_sys(clk_sys), .step_up(step_up), .step_dn(step_dn),
      .enc_a(enc_a), .enc_b(enc_b)
   );

   task automatic tick(input int n);
      repeat (n) @(negedge clk_sys);
   endtask

   task automatic cfg_wr(input cfg_t w, input logic ok);
      cfg_in = w;
      cfg_write = 1'b1;
      tick(1);
      cfg_write = 1'b0;
      `CHK("cfg_accepted", ok, cfg_accepted)
      `CHK("cfg_refused", ~ok, cfg_refused)
      tick(1);
   endtask

   task automatic move(input int n, input logic up);
      step_up = up;
      step_dn = ~up;
      tick(n);
      step_up = 1'b0;
      step_dn = 1'b0;
      tick(2);
      exp_pos = up ? exp_pos + 32'(4 * n / 4) : exp_pos - 32'(n);
      `CHK("position_count", exp_pos, position_count)
   endtask

   task automatic test_done;
      $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // ----------------------------------------
   // Tests
   // ----------------------------------------
   initial begin
      tick(10);
      rstn = 1'b1;
      tick(1);
      c = '{7'h05, 14'h000a, 1'b0, 5'h1f, 5'h1f, 2'h0, 2'h2};
      `CHK("cfg_active", c, cfg_active)
      $display("test defaults done");
      c.hold_gain = 7'h64;
      c.hold_window_count = 14'h3fff;
      cfg_wr(c, 1'b1);
      c.hold_gain = 7'h65;
      cfg_wr(c, 1'b0);
      for (int l = 0; l < 4; l++) begin
         cfg_wr('{7'h05, 14'h0003, 1'b0, 5'h00, 5'h01, 2'(l), 2'h2},
            l < 2);
         cfg_wr('{7'h05, 14'h0003, 1'b0, 5'h1f, 5'h1f, 2'h1, 2'(l)},
            l < 3);
      end
      cfg_wr('{7'h05, 14'h0003, 1'b0, 5'h1f, 5'h00, 2'h0, 2'h2},
         1'b0);
      cfg_wr('{7'h05, 14'h0003, 1'b1, 5'h13, 5'h1f, 2'h1, 2'h2},
         1'b0);
      `CHK("window", 14'h0003, cfg_active.hold_window_count)
      $display("test settings done");
      move(8, 1'b1);
      move(3, 1'b0);
      $display("test encoder done");
      di_sel[0] = 8'h71;
      di_sel[2] = 8'h72;
      do_sel[0] = 8'h32;
      do_sel[1] = 8'h33;
      run_cmd = 1'b1;
      speed_ref = 16'sh0010;
      digital_in = 6'b000001;
      tick(3);
      `CHK("hold_active", 1'b0, hold_active)
      speed_ref = -16'sh0200;
      digital_in = 6'b000100;
      tick(3);
      `CHK("hold_active", 1'b0, hold_active)
      speed_ref = -16'sh0010;
      tick(2);
      `CHK("hold_active", 1'b1, hold_active)
      `CHK("digital_out", 3'b010, digital_out)
      cfg_wr('{7'h05, 14'h0005, 1'b0, 5'h1f, 5'h1f, 2'h0, 2'h2},
         1'b0);
      move(3, 1'b1);
      `CHK("digital_out", 3'b010, digital_out)
      move(1, 1'b1);
      `CHK("position_error", 32'sd4, position_error)
      `CHK("hold_correction", -40'sd20, hold_corr)
      `CHK("digital_out", 3'b000, digital_out)
      move(4, 1'b0);
      `CHK("digital_out", 3'b010, digital_out)
      digital_in = 6'b000000;
      tick(1);
      `CHK("hold/out", 4'h0, {hold_active, digital_out})
      digital_in = 6'b000100;
      tick(2);
      zsl = 16'h0010;
      tick(1);
      `CHK("hold_active", 1'b0, hold_active)
      zsl = 16'h0100;
      tick(1);
      run_cmd = 1'b0;
      tick(1);
      `CHK("drive/hold", 2'b00, {drive_enable, hold_active})
      $display("test hold done");
      flux = 1'b1;
      cfg_wr('{7'h05, 14'h0003, 1'b1, 5'h13, 5'h1f, 2'h1, 2'h2},
         1'b1);
      run_cmd = 1'b1;
      multi_input = -16'sh0064;
      tick(2);
      `CHK("mode/valid", 2'b11, {torque_mode, torque_ref_valid})
      `CHK("torque_ref", -16'sh0064, torque_ref)
      cfg_wr('{7'h05, 14'h0003, 1'b0, 5'h1f, 5'h1f, 2'h0, 2'h2},
         1'b0);
      run_cmd = 1'b0;
      tick(1);
      cfg_wr('{7'h05, 14'h0003, 1'b1, 5'h13, 5'h1f, 2'h0, 2'h2},
         1'b1);
      run_cmd = 1'b1;
      tick(2);
      `CHK("torque_ref", 16'sh0000, torque_ref)
      run_cmd = 1'b0;
      tick(1);
      cfg_wr('{7'h05, 14'h0003, 1'b1, 5'h1f, 5'h13, 2'h0, 2'h2},
         1'b1);
      run_cmd = 1'b1;
      current_input = 16'sh0040;
      tick(2);
      `CHK("torque_ref", 16'sh0040, torque_ref)
      flux = 1'b0;
      tick(2);
      `CHK("torque_mode", 1'b0, torque_mode)
      $display("test torque done");
      test_done();
   end

   initial begin
      repeat (2000) @(posedge clk_sys);
      miscompares++;
      test_done();
   end
endmodule
